// File: include/surge_seq_pkg.sv
package surge_seq_pkg;
    // ==========
    // clock and timing
    localparam int unsigned CLK_KHZ        = 100000;
    localparam int unsigned STILL_MS       = 80;
    localparam int unsigned ALIGN_MS       = 640;
    localparam int unsigned RAMP_MS        = 300;
    localparam int unsigned STILL_CYC      = STILL_MS * CLK_KHZ;
    localparam int unsigned ALIGN_CYC      = ALIGN_MS * CLK_KHZ;
    localparam int unsigned ALIGN_LEVEL    = 256;
    localparam int unsigned RAMP_STEP_CYC  = (RAMP_MS * CLK_KHZ) / ALIGN_LEVEL;
    localparam int unsigned ACCEL_STEP_CYC = 100000;
    localparam int unsigned SLEW_STEP_CYC  = 10000;
    localparam int unsigned CLAMP_CYC      = 50000;
    // ==========
    // command conversion
    localparam logic [15:0] STANDBY_DUTY   = 16'h00f9;
    localparam logic [8:0]  ALIGN_AMP      = 9'h100;
    localparam int unsigned AMP_LSB        = 7;
    localparam int unsigned KT_SHIFT       = 12;
    localparam logic [15:0] ACCEL_INC      = 16'h0005;
    // handoff in tenths of a hertz
    localparam logic [15:0] HANDOFF_ZERO   = 16'h036b;
    localparam logic [11:0] HANDOFF_UNIT   = 12'h07d;
    // ==========
    // register map
    localparam logic [3:0]  CMD_ADDR       = 4'h0;
    localparam logic [3:0]  STATUS_ADDR    = 4'h4;
    localparam logic [3:0]  MOTOR_ADDR     = 4'h8;
    localparam logic [3:0]  COAST_ADDR     = 4'hc;
    localparam logic [15:0] CMD_RESET      = 16'h0000;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
    // ==========
    // sequencer states and drive carrier
    typedef enum logic [2:0] {
        S_IDLE, S_DETECT, S_ALIGN, S_OPEN, S_CLOSED
    } seq_e;
    typedef struct packed {
        logic [2:0] hiz;   // 1 = phase in high impedance, u at bit 0
        logic [2:0] low;   // 1 = low-side switch forced on
        logic [8:0] amp;   // amplitude on driven phases
    } drive_s;
endpackage : surge_seq_pkg

// File: core/surge_seq.sv
// Operation
// - speed command is buffered and the effective command moves one step per slew tick.
// - effective amplitude never drops to or below the back-EMF estimate.
// - back-EMF estimate is torque constant times current speed.
// - on stopping a driven motor, low-side switches turn on to dump winding current.
// - thermal trip locks out; release only below trip minus hysteresis.
// - supply lockout clears above rise threshold, sets below fall threshold.
// - handoff threshold comes from the handoff select input level code.
// - code 0 gives 87.5 Hz, other codes 12.5 Hz times code.
// - torque constant and winding resistance are captured at handoff to closed loop and kept.
// - during initial speed detect all phases are high impedance.
// - coasting period is time between two rising edges of either comparator.
// - no comparator toggle for 80 ms means stationary, go to align.
// - while comparators keep toggling, keep waiting without driving.
// - align drives v and w at 50 percent, u low, for 0.64 s.
// - align duty ramps up to 50 percent over 0.3 s.
// - open-loop reaching handoff frequency switches to closed loop.
// - closed loop uses internal commutation, amplitude follows the command.
// - duty command converts to a 9-bit amplitude 0 to 511.
// - duty below 0.38 percent stops driving and enters standby.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module surge_seq #(
    parameter int unsigned STILL_LEN  = surge_seq_pkg::STILL_CYC,
    parameter int unsigned ALIGN_LEN  = surge_seq_pkg::ALIGN_CYC,
    parameter int unsigned RAMP_STEP  = surge_seq_pkg::RAMP_STEP_CYC,
    parameter int unsigned ACCEL_STEP = surge_seq_pkg::ACCEL_STEP_CYC,
    parameter int unsigned SLEW_STEP  = surge_seq_pkg::SLEW_STEP_CYC,
    parameter int unsigned CLAMP_LEN  = surge_seq_pkg::CLAMP_CYC
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [3:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output var  logic                 s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output var  logic                 s_axi_wready,
    output var  logic [1:0]           s_axi_bresp,
    output var  logic                 s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [3:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output var  logic                 s_axi_arready,
    output var  logic [31:0]          s_axi_rdata,
    output var  logic [1:0]           s_axi_rresp,
    output var  logic                 s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 cmp_a,
    input  wire logic                 cmp_b,
    input  wire logic                 thermal_trip_level,
    input  wire logic                 thermal_hysteresis,
    input  wire logic                 supply_rise_threshold,
    input  wire logic                 supply_fall_threshold,
    input  wire logic [3:0]           handoff_sel,
    input  wire logic [15:0]          comm_freq,
    input  wire logic [7:0]           kt_meas,
    input  wire logic [7:0]           winding_resistance,
    output var  surge_seq_pkg::drive_s drive,
    output var  logic [2:0]           seq_state,
    output var  logic [15:0]          ol_freq
);
    // ==========
    // pin synchronisers: three stages, change taken once 2nd and 3rd agree
    localparam int unsigned NPIN = 10;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_f;
    assign pin_raw = {handoff_sel, supply_fall_threshold, supply_rise_threshold,
                      thermal_hysteresis, thermal_trip_level, cmp_b, cmp_a};
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            logic s1_r, s2_r, s3_r, f_r;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    f_r  <= 1'b0;
                end else begin
                    s1_r <= pin_raw[gi];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    f_r  <= (s2_r == s3_r) ? s3_r : f_r;
                end
            end
            assign pin_f[gi] = f_r;
        end
    endgenerate
    wire logic       ca_w      = pin_f[0];
    wire logic       cb_w      = pin_f[1];
    wire logic       ot_trip_w = pin_f[2];
    wire logic       ot_rel_w  = pin_f[3];
    wire logic       sup_up_w  = pin_f[4];
    wire logic       sup_dn_w  = pin_f[5];
    wire logic [3:0] code_w    = pin_f[9:6];

    // ==========
    // lockouts; supply lockout starts asserted until the rise threshold is seen
    logic uv_lock_r, ot_lock_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            uv_lock_r <= 1'b1;
            ot_lock_r <= 1'b0;
        end else begin
            if (sup_dn_w) uv_lock_r <= 1'b1;
            else if (sup_up_w) uv_lock_r <= 1'b0;
            if (ot_trip_w) ot_lock_r <= 1'b1;
            else if (ot_rel_w) ot_lock_r <= 1'b0;
        end
    end
    wire logic lock_w = uv_lock_r | ot_lock_r;

    // ==========
    // command buffer, conversion and standby decode
    logic [15:0] cmd_r;
    logic [8:0]  eff_r;
    logic [7:0]  kt_r, res_r;
    logic [15:0] speed_w;
    wire logic        standby_w = cmd_r < surge_seq_pkg::STANDBY_DUTY;
    wire logic [8:0]  tgt_w     = standby_w ? 9'h000
                                : cmd_r[15:surge_seq_pkg::AMP_LSB];
    // back-emf estimate, saturated to the amplitude range
    wire logic [23:0] bemf_p_w  = kt_r * speed_w;
    wire logic [23:0] bemf_s_w  = bemf_p_w >> surge_seq_pkg::KT_SHIFT;
    wire logic [8:0]  bemf_w    = (|bemf_s_w[23:9]) ? 9'h1ff : bemf_s_w[8:0];
    // a step down is only allowed while it stays above the estimate
    wire logic        dn_ok_w   = (eff_r - 9'h001) > bemf_w;

    // ==========
    // handoff threshold in tenths of a hertz
    wire logic [15:0] handoff_w = (code_w == 4'h0) ? surge_seq_pkg::HANDOFF_ZERO
                                : 16'(code_w * surge_seq_pkg::HANDOFF_UNIT);

    // ==========
    // slew limiter: one step per tick keeps a sudden drop from regenerating
    logic [31:0] slew_cnt_r;
    wire logic   slew_tick_w = slew_cnt_r == SLEW_STEP - 1;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slew_cnt_r <= '0;
            eff_r      <= 9'h000;
        end else begin
            slew_cnt_r <= slew_tick_w ? '0 : slew_cnt_r + 32'h1;
            if (slew_tick_w && tgt_w > eff_r) eff_r <= eff_r + 9'h001;
            else if (slew_tick_w && tgt_w < eff_r && dn_ok_w) eff_r <= eff_r - 9'h001;
        end
    end

    // ==========
    // start-up sequencer
    surge_seq_pkg::seq_e st_r;
    logic [31:0] cnt_r, step_r, clamp_r;
    logic [31:0] coast_r;
    logic [8:0]  ramp_r;
    logic        ca_d_r, cb_d_r;
    wire logic   rise_w   = (ca_w & ~ca_d_r) | (cb_w & ~cb_d_r);
    wire logic   driving_w = (st_r == surge_seq_pkg::S_ALIGN) || (st_r == surge_seq_pkg::S_OPEN)
                          || (st_r == surge_seq_pkg::S_CLOSED);
    wire logic   stop_w   = lock_w | standby_w;
    assign speed_w = (st_r == surge_seq_pkg::S_CLOSED) ? comm_freq : ol_freq;

    // stop handling has priority over every state step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r    <= surge_seq_pkg::S_IDLE;
            cnt_r   <= '0;
            step_r  <= '0;
            clamp_r <= '0;
            coast_r <= '0;
            ramp_r  <= 9'h000;
            ol_freq <= 16'h0000;
            kt_r    <= 8'h00;
            res_r   <= 8'h00;
            ca_d_r  <= 1'b0;
            cb_d_r  <= 1'b0;
        end else begin
            ca_d_r <= ca_w;
            cb_d_r <= cb_w;
            if (clamp_r != '0) clamp_r <= clamp_r - 32'h1;
            if (stop_w && st_r != surge_seq_pkg::S_IDLE) begin
                st_r <= surge_seq_pkg::S_IDLE;
                if (driving_w) clamp_r <= CLAMP_LEN;
            end else begin
                unique case (st_r)
                    surge_seq_pkg::S_IDLE: begin
                        cnt_r <= '0;
                        if (!stop_w) st_r <= surge_seq_pkg::S_DETECT;
                    end
                    surge_seq_pkg::S_DETECT: begin
                        if (rise_w) begin
                            coast_r <= cnt_r + 32'h1;
                            cnt_r   <= '0;
                        end else if (cnt_r == STILL_LEN - 1) begin
                            st_r   <= surge_seq_pkg::S_ALIGN;
                            cnt_r  <= '0;
                            step_r <= '0;
                            ramp_r <= 9'h000;
                        end else begin
                            cnt_r <= cnt_r + 32'h1;
                        end
                    end
                    surge_seq_pkg::S_ALIGN: begin
                        cnt_r <= cnt_r + 32'h1;
                        step_r <= (step_r == RAMP_STEP - 1) ? '0 : step_r + 32'h1;
                        if (step_r == RAMP_STEP - 1 && ramp_r < surge_seq_pkg::ALIGN_AMP)
                            ramp_r <= ramp_r + 9'h001;
                        if (cnt_r == ALIGN_LEN - 1) begin
                            st_r    <= surge_seq_pkg::S_OPEN;
                            step_r  <= '0;
                            ol_freq <= 16'h0000;
                        end
                    end
                    surge_seq_pkg::S_OPEN: begin
                        step_r <= (step_r == ACCEL_STEP - 1) ? '0 : step_r + 32'h1;
                        if (step_r == ACCEL_STEP - 1)
                            ol_freq <= ol_freq + surge_seq_pkg::ACCEL_INC;
                        if (ol_freq >= handoff_w) begin
                            st_r <= surge_seq_pkg::S_CLOSED;
                            kt_r <= kt_meas;
                            res_r <= winding_resistance;
                        end
                    end
                    surge_seq_pkg::S_CLOSED: begin
                        cnt_r <= '0;
                    end
                endcase
            end
        end
    end

    // ==========
    // phase drive; closed loop commutation comes from the control core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive     <= '{hiz: 3'b111, low: 3'b000, amp: 9'h000};
            seq_state <= 3'h0;
        end else begin
            seq_state <= st_r;
            unique case (st_r)
                surge_seq_pkg::S_ALIGN:
                    drive <= '{hiz: 3'b000, low: 3'b001, amp: ramp_r};
                surge_seq_pkg::S_OPEN:
                    drive <= '{hiz: 3'b000, low: 3'b000, amp: surge_seq_pkg::ALIGN_AMP};
                surge_seq_pkg::S_CLOSED:
                    drive <= '{hiz: 3'b000, low: 3'b000, amp: eff_r};
                default:
                    // clamp window keeps the low sides on after a stop
                    drive <= '{hiz: 3'b111, low: (clamp_r != '0) ? 3'b111 : 3'b000,
                               amp: 9'h000};
            endcase
        end
    end

    // ==========
    // axi4-lite slave; address and data may arrive in either order
    logic        aw_got_r, w_got_r;
    logic [3:0]  aw_a_r;
    logic [31:0] w_d_r;
    logic [3:0]  w_s_r;
    wire logic aw_hs_w = s_axi_awvalid & s_axi_awready;
    wire logic w_hs_w  = s_axi_wvalid & s_axi_wready;
    wire logic wr_go_w = aw_got_r & w_got_r & ~s_axi_bvalid;
    wire logic wr_ok_w = aw_a_r == surge_seq_pkg::CMD_ADDR;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            aw_a_r   <= 4'h0;
            w_d_r    <= 32'h0;
            w_s_r    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= surge_seq_pkg::RESP_OKAY;
            cmd_r <= surge_seq_pkg::CMD_RESET;
        end else begin
            s_axi_awready <= ~aw_got_r & ~aw_hs_w & ~s_axi_bvalid;
            s_axi_wready  <= ~w_got_r & ~w_hs_w & ~s_axi_bvalid;
            if (aw_hs_w) begin
                aw_got_r <= 1'b1;
                aw_a_r   <= s_axi_awaddr;
            end
            if (w_hs_w) begin
                w_got_r <= 1'b1;
                w_d_r   <= s_axi_wdata;
                w_s_r   <= s_axi_wstrb;
            end
            if (wr_go_w) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok_w ? surge_seq_pkg::RESP_OKAY : surge_seq_pkg::RESP_SLVERR;
                if (wr_ok_w && w_s_r[0]) cmd_r[7:0]  <= w_d_r[7:0];
                if (wr_ok_w && w_s_r[1]) cmd_r[15:8] <= w_d_r[15:8];
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read mux; unmapped offsets answer zero with an error response
    logic [31:0] rd_w;
    logic        rd_ok_w;
    always_comb begin
        rd_ok_w = 1'b1;
        unique case (s_axi_araddr)
            surge_seq_pkg::CMD_ADDR:    rd_w = {16'h0000, cmd_r};
            surge_seq_pkg::STATUS_ADDR: rd_w = {9'h000, eff_r, 7'h00, standby_w,
                                                ot_lock_r, uv_lock_r, 1'b0, st_r};
            surge_seq_pkg::MOTOR_ADDR:  rd_w = {16'h0000, res_r, kt_r};
            surge_seq_pkg::COAST_ADDR:  rd_w = coast_r;
            default: begin
                rd_w    = 32'h0;
                rd_ok_w = 1'b0;
            end
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= surge_seq_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_w;
                s_axi_rresp  <= rd_ok_w ? surge_seq_pkg::RESP_OKAY : surge_seq_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : surge_seq
`default_nettype wire

// File: dv/motor_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// coasting rotor seen through the phase comparators
module motor_model (
    input  wire logic                  aclk,
    input  wire surge_seq_pkg::drive_s drive,
    input  wire logic [15:0]           half_per,
    output var  logic                  cmp_a,
    output var  logic                  cmp_b
);
    logic [15:0] cnt_r;

    initial begin
        cmp_a = 1'b0;
        cnt_r = 16'h0000;
    end
    // crossings show only while all phases float; a zero half period is a
    // stopped rotor, so the comparators hold still
    always @(posedge aclk) begin
        if (drive.hiz != 3'h7 || half_per == 16'h0000) begin
            cnt_r <= 16'h0000;
        end else if (cnt_r >= half_per - 16'h0001) begin
            cnt_r <= 16'h0000;
            cmp_a <= ~cmp_a;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
    // both pairs cross together, so the edge interval is one full period
    assign cmp_b = cmp_a;
endmodule : motor_model
`default_nettype wire

// File: dv/surge_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checks of the start-up sequencer
module surge_seq_checker #(
    parameter int unsigned CLAMP_LEN = 10
) (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  thermal_trip_level,
    input wire logic                  supply_fall_threshold,
    input wire logic [3:0]            handoff_sel,
    input wire logic [15:0]           comm_freq,
    input wire logic [7:0]            kt_meas,
    input wire surge_seq_pkg::drive_s drive,
    input wire logic [2:0]            seq_state,
    input wire logic [15:0]           ol_freq
);
    logic [23:0] prod;
    logic [8:0]  bemf;
    logic [15:0] ho;
    logic [15:0] clamp_cnt_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // back-emf estimate saturates like the amplitude range
    assign prod = kt_meas * comm_freq;
    assign bemf = (|prod[23:21]) ? 9'h1ff : prod[20:12];
    assign ho   = (handoff_sel == 4'h0) ? 16'h036b : 16'h007d * handoff_sel;
    // length of the current low-side clamp
    always_ff @(posedge aclk) begin
        if (!aresetn || drive.low != 3'h7)
            clamp_cnt_r <= 16'h0000;
        else
            clamp_cnt_r <= clamp_cnt_r + 16'h0001;
    end
    // ==========
    // assertions; drive and state update on the same edge
    AST_DETECT_HIZ: assert property (seq_state == 3'h1 |-> drive.hiz == 3'h7)
        else $error("phase driven during speed detect");
    AST_ALIGN_PINS: assert property (seq_state == 3'h2 |-> drive.hiz == 3'h0 && drive.low == 3'h1)
        else $error("align phase pattern wrong");
    AST_ALIGN_RAMP: assert property ((seq_state == 3'h2)[*2] |-> drive.amp <= 9'h100
        && drive.amp <= $past(drive.amp) + 9'h001) else $error("align ramp stepped");
    AST_ORDER: assert property ($changed(seq_state) && seq_state != 3'h0
        |-> seq_state == $past(seq_state) + 3'h1) else $error("start-up state skipped");
    AST_HANDOFF: assert property (seq_state == 3'h3 && ol_freq >= ho |-> ##[1:3] seq_state == 3'h4)
        else $error("no handoff at threshold");
    AST_SLEW: assert property ((seq_state == 3'h4)[*3] |-> drive.amp inside
        {$past(drive.amp), $past(drive.amp) + 9'h001, $past(drive.amp) - 9'h001})
        else $error("amplitude jumped");
    AST_FLOOR: assert property ((seq_state == 3'h4)[*3] ##0 drive.amp < $past(drive.amp)
        |-> drive.amp > bemf) else $error("amplitude fell to back-emf");
    AST_CLAMP_ON: assert property (seq_state == 3'h0 && $past(seq_state) >= 3'h2
        |-> ##[0:2] drive.low == 3'h7) else $error("no clamp on stop");
    AST_CLAMP_LEN: assert property ($fell(drive.low == 3'h7) |-> clamp_cnt_r == 16'(CLAMP_LEN))
        else $error("clamp length wrong");
    AST_THERMAL: assert property ($rose(thermal_trip_level) |-> ##[1:8] seq_state == 3'h0)
        else $error("thermal trip ignored");
    AST_SUPPLY: assert property ($rose(supply_fall_threshold) |-> ##[1:8] seq_state == 3'h0)
        else $error("supply drop ignored");
    cover property (seq_state == 3'h2 ##1 seq_state == 3'h3);
    cover property (seq_state == 3'h3 ##1 seq_state == 3'h4);
    cover property ($fell(drive.low == 3'h7));
endmodule : surge_seq_checker
bind surge_seq surge_seq_checker #(.CLAMP_LEN(CLAMP_LEN)) chk (.aclk(aclk), .aresetn(aresetn),
    .thermal_trip_level(thermal_trip_level), .supply_fall_threshold(supply_fall_threshold),
    .handoff_sel(handoff_sel), .comm_freq(comm_freq), .kt_meas(kt_meas), .drive(drive),
    .seq_state(seq_state), .ol_freq(ol_freq));
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// sequencer bench: register traffic plus pin stimulus
module testbench;
    logic        aclk = 1'b0;
    logic        aresetn, cmp_a, cmp_b, thermal_trip_level, thermal_hysteresis;
    logic        supply_rise_threshold, supply_fall_threshold;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, handoff_sel;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] comm_freq, ol_freq, half_per, ho;
    logic [7:0]  kt_meas, winding_resistance;
    logic [2:0]  seq_state;
    surge_seq_pkg::drive_s drive;
    int          err_total, comparisons, cycles, n;

    // short counts keep the run brief
    surge_seq #(.STILL_LEN(50), .ALIGN_LEN(300), .RAMP_STEP(1), .ACCEL_STEP(2),
        .SLEW_STEP(4), .CLAMP_LEN(10)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_a, .cmp_b,
        .thermal_trip_level, .thermal_hysteresis, .supply_rise_threshold,
        .supply_fall_threshold, .handoff_sel, .comm_freq, .kt_meas, .winding_resistance,
        .drive, .seq_state, .ol_freq);
    motor_model motor (.aclk, .drive, .half_per, .cmp_a, .cmp_b);

    always #5 aclk = ~aclk;
    // hang guard, about three and a half times the expected run
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_total++;
            stop_test();
        end
    end
    // ==========
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    // bounded wait for a sequencer state, n gives the cycles spent
    task automatic wait_st(input logic [2:0] s);
        n = 0;
        while (seq_state !== s && n < 4000) begin
            @(posedge aclk);
            n++;
        end
    endtask : wait_st
    // ==========
    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
        {s_axi_rready, thermal_trip_level, supply_rise_threshold} = 3'h0;
        {thermal_hysteresis, supply_fall_threshold} = 2'h3;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, handoff_sel} = 44'h0;
        {comm_freq, kt_meas, winding_resistance, half_per} = 56'h1000_8000_0000;
        s_axi_wstrb = 4'hf;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check(drive, 15'h7000);
        axi_rd(surge_seq_pkg::CMD_ADDR);
        check(d, 32'h0000_0000);
        axi_wr(surge_seq_pkg::STATUS_ADDR, 32'h0000_0001);
        check(r, surge_seq_pkg::RESP_SLVERR);
        axi_wr(surge_seq_pkg::CMD_ADDR, 32'h0000_8000);
        repeat (20) @(posedge aclk);
        check(seq_state, 3'h0);
        supply_fall_threshold <= 1'b0;
        supply_rise_threshold <= 1'b1;
        half_per <= 16'h000a;
        wait_st(3'h1);
        check(seq_state, 3'h1);
        repeat (300) @(posedge aclk);
        check(seq_state, 3'h1);
        axi_rd(surge_seq_pkg::COAST_ADDR);
        check(d, 32'h0000_0014);
        @(posedge cmp_a);
        @(posedge aclk);
        half_per <= 16'h0000;
        wait_st(3'h2);
        check(n >= 46 && n <= 58, 1'b1);
        wait_st(3'h3);
        check(n, 300);
        check(drive.amp, 9'h100);
        wait_st(3'h4);
        check(ol_freq >= 16'h036b && ol_freq <= 16'h0370, 1'b1);
        repeat (2100) @(posedge aclk);
        check(drive.amp, 9'h100);
        axi_wr(surge_seq_pkg::CMD_ADDR, 32'h0000_0100);
        repeat (40) @(posedge aclk);
        check(drive.amp > 9'h0f0, 1'b1);
        repeat (800) @(posedge aclk);
        check(drive.amp, 9'h081);
        axi_rd(surge_seq_pkg::STATUS_ADDR);
        check(d[22:14], 9'h081);
        comm_freq <= 16'h0000;
        repeat (700) @(posedge aclk);
        check(drive.amp, 9'h002);
        axi_wr(surge_seq_pkg::CMD_ADDR, 32'h0000_0000);
        wait_st(3'h0);
        @(posedge aclk);
        check(drive.low, 3'h7);
        axi_rd(surge_seq_pkg::STATUS_ADDR);
        check(d[6], 1'b1);
        // every nonzero handoff code, estimator values kept after handoff
        for (int c = 1; c < 16; c++) begin
            handoff_sel <= c[3:0];
            {kt_meas, winding_resistance} <= {2{c[7:0]}};
            ho = 16'h007d * c[15:0];
            axi_wr(surge_seq_pkg::CMD_ADDR, 32'h0000_8000);
            wait_st(3'h4);
            check(ol_freq >= ho && ol_freq <= ho + 16'h0005, 1'b1);
            {kt_meas, winding_resistance} <= 16'hffff;
            axi_rd(surge_seq_pkg::MOTOR_ADDR);
            check(d[15:0], {2{c[7:0]}});
            axi_wr(surge_seq_pkg::CMD_ADDR, 32'h0000_0000);
            wait_st(3'h0);
        end
        // lockouts and their release bands; low byte lane masked off
        s_axi_wstrb <= 4'h2;
        axi_wr(surge_seq_pkg::CMD_ADDR, 32'h0000_8080);
        axi_rd(surge_seq_pkg::CMD_ADDR);
        check(d, 32'h0000_8000);
        wait_st(3'h1);
        thermal_trip_level <= 1'b1;
        thermal_hysteresis <= 1'b0;
        wait_st(3'h0);
        thermal_trip_level <= 1'b0;
        repeat (100) @(posedge aclk);
        check(seq_state, 3'h0);
        thermal_hysteresis <= 1'b1;
        wait_st(3'h1);
        check(seq_state, 3'h1);
        supply_rise_threshold <= 1'b0;
        supply_fall_threshold <= 1'b1;
        wait_st(3'h0);
        supply_fall_threshold <= 1'b0;
        repeat (100) @(posedge aclk);
        check(seq_state, 3'h0);
        supply_rise_threshold <= 1'b1;
        wait_st(3'h1);
        check(seq_state, 3'h1);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
